// File: hdl/blc_pkg.sv
// Contract
// - The lead contact flag is set only after the comparator has seen the positive sense input below threshold without a break for at least 128 ms.
// - With the contact interrupt enable bit set, the device raises its interrupt once the contact flag is set.
// - Reading the event status register clears the contact flag, and a second read tells the host whether contact still persists.
// - The reference resistor is switched onto the calibration port only while both the port switch enable and the calibration enable bits are set.
// - Setting the drive short bit shorts the load for offset measurement, and clearing it removes the short.
// - A one in the quadrature phase select bit moves the quadrature demodulation clock to in-phase, a zero keeps it in quadrature.
// - A one in the in-phase phase select bit moves the in-phase demodulation clock to quadrature, a zero keeps it in phase.
// - Zero in both the voltage magnitude and current range fields selects the minimum 16 nA RMS stimulus.
package blc_pkg;

  // ***************************************************************
  // register offsets
  // ***************************************************************
  localparam logic [7:0] OFF_EVENT_STATUS = 8'h01;
  localparam logic [7:0] OFF_CHANNEL_ENABLE = 8'h20;
  localparam logic [7:0] OFF_STIMULUS_MAG = 8'h22;
  localparam logic [7:0] OFF_DRIVE_RESET = 8'h25;
  localparam logic [7:0] OFF_DEMOD_PHASE = 8'h28;
  localparam logic [7:0] OFF_CAL_MUX = 8'h41;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h81;
  localparam logic [7:0] OFF_CONTACT_DETECT = 8'h83;

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int unsigned BIT_CONTACT_FLAG = 7;
  localparam int unsigned BIT_INPHASE_EN = 0;
  localparam int unsigned BIT_QUAD_EN = 1;
  localparam int unsigned BIT_IRANGE_LO = 2;
  localparam int unsigned BIT_VMAG_LO = 4;
  localparam int unsigned BIT_DRIVE_SHORT = 5;
  localparam int unsigned BIT_INPHASE_PHASE = 2;
  localparam int unsigned BIT_QUAD_PHASE = 3;
  localparam int unsigned BIT_CAL_EN = 0;
  localparam int unsigned BIT_PORT_SWITCH = 1;
  localparam int unsigned BIT_DETECT_EN = 0;
  localparam int unsigned BIT_DETECT_ACTIVE = 1;
  localparam int unsigned BIT_DETECT_BELOW = 2;

  // writable bits of each register; the rest read as zero, except the active and below bits of the contact detect register
  localparam logic [7:0] MASK_CHANNEL_ENABLE = 8'h03;
  localparam logic [7:0] MASK_STIMULUS_MAG = 8'h3c;
  localparam logic [7:0] MASK_DRIVE_RESET = 8'h20;
  localparam logic [7:0] MASK_DEMOD_PHASE = 8'h0c;
  localparam logic [7:0] MASK_CAL_MUX = 8'h03;
  localparam logic [7:0] MASK_IRQ_ENABLE = 8'h80;
  localparam logic [7:0] MASK_CONTACT_DETECT = 8'h01;

  // ***************************************************************
  // reset values
  // ***************************************************************
  localparam logic [7:0] RST_CTRL = 8'h00;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned QUAL_TIME_MS = 128;
  // least time, exact at this rate so no rounding is lost
  localparam int unsigned QUAL_CYCLES = QUAL_TIME_MS * (CLK_HZ / 1000);

endpackage

// File: hdl/blc_qual_timer.sv
`timescale 1ns/10ps
`default_nettype none
module blc_qual_timer #(
  parameter int unsigned QUAL_CYCLES = blc_pkg::QUAL_CYCLES
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  input wire logic enable,
  input wire logic below,
  output logic qualified
);

  localparam int unsigned CW = $clog2(QUAL_CYCLES + 1);

  generate
    if (QUAL_CYCLES < 1) begin : g_bad
      $error("qualification count must be at least one");
    end
  endgenerate

  typedef enum logic [1:0] {T_IDLE, T_COUNT, T_QUAL} blc_timer_state_t;

  blc_timer_state_t state_reg;
  blc_timer_state_t state_next;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;

  // ***************************************************************
  // qualification timer
  // ***************************************************************
  // counts consecutive low samples; one high sample drops back to idle
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    if (!enable || !below) begin
      state_next = T_IDLE;
      cnt_next = '0;
    end else begin
      unique case (state_reg)
        T_IDLE: begin
          cnt_next = CW'(1);
          state_next = (QUAL_CYCLES == 1) ? T_QUAL : T_COUNT;
        end
        T_COUNT: begin
          if (cnt_reg == CW'(QUAL_CYCLES - 1)) begin
            state_next = T_QUAL;
          end else begin
            cnt_next = cnt_reg + CW'(1);
          end
        end
        T_QUAL: begin
          state_next = T_QUAL; // held while contact persists
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_reg <= T_IDLE;
      cnt_reg <= '0;
    end else if (ce) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  assign qualified = (state_reg == T_QUAL);

endmodule
`default_nettype wire

// File: hdl/blc_evt_status.sv
`timescale 1ns/10ps
`default_nettype none
module blc_evt_status #(
  parameter int unsigned W = 1
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  input wire logic [W-1:0] mask,
  output logic [W-1:0] status,
  output logic irq
);

  generate
    if (W < 1) begin : g_bad
      $error("status width must be at least one");
    end
  endgenerate

  logic [W-1:0] status_reg;
  logic [W-1:0] status_next;
  logic irq_reg;
  logic irq_next;

  // ***************************************************************
  // sticky status
  // ***************************************************************
  // set wins over a clear in the same cycle so no event is lost
  always_comb begin
    status_next = (status_reg & ~clr) | set;
    irq_next = |(status_next & mask);
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      status_reg <= '0;
      irq_reg <= 1'b0;
    end else if (ce) begin
      status_reg <= status_next;
      irq_reg <= irq_next;
    end
  end

  assign status = status_reg;
  assign irq = irq_reg;

endmodule
`default_nettype wire

// File: hdl/blc_lead_cal_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module blc_lead_cal_ctrl #(
  parameter int unsigned QUAL_CYCLES = blc_pkg::QUAL_CYCLES
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // contact comparator, high while the positive sense input is below threshold
  input wire logic contact_below_thresh,
  output logic irq,
  output logic contact_detect_active,
  // receive channels
  output logic inphase_channel_enable,
  output logic quadrature_channel_enable,
  output logic inphase_channel_phase_select,
  output logic quad_channel_phase_select,
  // stimulus
  output logic [1:0] voltage_drive_magnitude,
  output logic [1:0] current_drive_range,
  output logic stimulus_minimum,
  output logic drive_short_enable,
  // calibration port
  output logic cal_port_switch_enable,
  output logic cal_enable,
  output logic ref_resistor_connect
);

  generate
    if (QUAL_CYCLES < 1) begin : g_bad
      $error("qualification count must be at least one");
    end
  endgenerate

  // ***************************************************************
  // helpers
  // ***************************************************************
  function automatic logic wr_hit(
    input logic wr,
    input logic [7:0] addr,
    input logic [7:0] off
  );
    wr_hit = wr && (addr == off);
  endfunction

  // keeps only writable bits so reserved bits always read zero
  function automatic logic [7:0] upd(
    input logic hit,
    input logic [7:0] cur,
    input logic [7:0] wdata,
    input logic [7:0] msk
  );
    upd = hit ? (wdata & msk) : cur;
  endfunction

  // ***************************************************************
  // control registers
  // ***************************************************************
  logic [7:0] chan_reg;
  logic [7:0] chan_next;
  logic [7:0] stim_reg;
  logic [7:0] stim_next;
  logic [7:0] drv_reg;
  logic [7:0] drv_next;
  logic [7:0] phase_reg;
  logic [7:0] phase_next;
  logic [7:0] cmux_reg;
  logic [7:0] cmux_next;
  logic [7:0] mask_reg;
  logic [7:0] mask_next;
  logic [7:0] detect_reg;
  logic [7:0] detect_next;

  // derived outputs, registered from the next values so they move
  // in the same cycle as the fields they depend on
  logic ref_conn_reg;
  logic ref_conn_next;
  logic stim_min_reg;
  logic stim_min_next;
  logic active_reg;
  logic active_next;

  // software writes; a write in the cycle after reset release is taken
  always_comb begin
    chan_next = upd(wr_hit(reg_wr, reg_addr, blc_pkg::OFF_CHANNEL_ENABLE),
      chan_reg, reg_wdata, blc_pkg::MASK_CHANNEL_ENABLE);
    stim_next = upd(wr_hit(reg_wr, reg_addr, blc_pkg::OFF_STIMULUS_MAG),
      stim_reg, reg_wdata, blc_pkg::MASK_STIMULUS_MAG);
    drv_next = upd(wr_hit(reg_wr, reg_addr, blc_pkg::OFF_DRIVE_RESET),
      drv_reg, reg_wdata, blc_pkg::MASK_DRIVE_RESET);
    phase_next = upd(wr_hit(reg_wr, reg_addr, blc_pkg::OFF_DEMOD_PHASE),
      phase_reg, reg_wdata, blc_pkg::MASK_DEMOD_PHASE);
    cmux_next = upd(wr_hit(reg_wr, reg_addr, blc_pkg::OFF_CAL_MUX),
      cmux_reg, reg_wdata, blc_pkg::MASK_CAL_MUX);
    mask_next = upd(wr_hit(reg_wr, reg_addr, blc_pkg::OFF_IRQ_ENABLE),
      mask_reg, reg_wdata, blc_pkg::MASK_IRQ_ENABLE);
    detect_next = upd(wr_hit(reg_wr, reg_addr, blc_pkg::OFF_CONTACT_DETECT),
      detect_reg, reg_wdata, blc_pkg::MASK_CONTACT_DETECT);
  end

  // derived controls
  always_comb begin
    // both switch bits are needed before the resistor touches the port
    ref_conn_next = cmux_next[blc_pkg::BIT_PORT_SWITCH]
      && cmux_next[blc_pkg::BIT_CAL_EN];
    // all-zero magnitude and range is the smallest stimulus
    stim_min_next = (stim_next[blc_pkg::BIT_VMAG_LO +: 2] == 2'b00)
      && (stim_next[blc_pkg::BIT_IRANGE_LO +: 2] == 2'b00);
    // detection is held off while either channel runs, so a host that
    // forgets to clear the enables cannot corrupt a measurement
    active_next = detect_next[blc_pkg::BIT_DETECT_EN]
      && !chan_next[blc_pkg::BIT_INPHASE_EN]
      && !chan_next[blc_pkg::BIT_QUAD_EN];
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      chan_reg <= blc_pkg::RST_CTRL;
      stim_reg <= blc_pkg::RST_CTRL;
      drv_reg <= blc_pkg::RST_CTRL;
      phase_reg <= blc_pkg::RST_CTRL;
      cmux_reg <= blc_pkg::RST_CTRL;
      mask_reg <= blc_pkg::RST_CTRL;
      detect_reg <= blc_pkg::RST_CTRL;
      ref_conn_reg <= 1'b0;
      stim_min_reg <= 1'b1;
      active_reg <= 1'b0;
    end else if (ce) begin
      chan_reg <= chan_next;
      stim_reg <= stim_next;
      drv_reg <= drv_next;
      phase_reg <= phase_next;
      cmux_reg <= cmux_next;
      mask_reg <= mask_next;
      detect_reg <= detect_next;
      ref_conn_reg <= ref_conn_next;
      stim_min_reg <= stim_min_next;
      active_reg <= active_next;
    end
  end

  // ***************************************************************
  // contact qualification and status
  // ***************************************************************
  logic qualified;
  logic status_rd;
  logic [0:0] flag_clr;
  logic [0:0] flag_status;

  blc_qual_timer #(
    .QUAL_CYCLES(QUAL_CYCLES)
  ) u_timer (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ce(ce),
    .enable(active_reg),
    .below(contact_below_thresh),
    .qualified(qualified)
  );

  // a read clears the flag; while contact persists the level sets it
  // again at once, which is what a second read reports
  always_comb begin
    status_rd = reg_rd && (reg_addr == blc_pkg::OFF_EVENT_STATUS);
    flag_clr[0] = status_rd
      || (wr_hit(reg_wr, reg_addr, blc_pkg::OFF_EVENT_STATUS)
      && reg_wdata[blc_pkg::BIT_CONTACT_FLAG]);
  end

  blc_evt_status #(
    .W(1)
  ) u_status (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ce(ce),
    .set(qualified),
    .clr(flag_clr),
    .mask(mask_reg[blc_pkg::BIT_CONTACT_FLAG]),
    .status(flag_status),
    .irq(irq)
  );

  // ***************************************************************
  // read back
  // ***************************************************************
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [7:0] rd_mux;

  // unmapped offsets answer zero; data stand for one cycle only
  always_comb begin
    rd_mux = 8'h00;
    unique case (reg_addr)
      blc_pkg::OFF_EVENT_STATUS: begin
        rd_mux[blc_pkg::BIT_CONTACT_FLAG] = flag_status[0];
      end
      blc_pkg::OFF_CHANNEL_ENABLE: begin
        rd_mux = chan_reg;
      end
      blc_pkg::OFF_STIMULUS_MAG: begin
        rd_mux = stim_reg;
      end
      blc_pkg::OFF_DRIVE_RESET: begin
        rd_mux = drv_reg;
      end
      blc_pkg::OFF_DEMOD_PHASE: begin
        rd_mux = phase_reg;
      end
      blc_pkg::OFF_CAL_MUX: begin
        rd_mux = cmux_reg;
      end
      blc_pkg::OFF_IRQ_ENABLE: begin
        rd_mux = mask_reg;
      end
      blc_pkg::OFF_CONTACT_DETECT: begin
        rd_mux = detect_reg;
        rd_mux[blc_pkg::BIT_DETECT_ACTIVE] = active_reg;
        rd_mux[blc_pkg::BIT_DETECT_BELOW] = contact_below_thresh;
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
    rdata_next = reg_rd ? rd_mux : 8'h00;
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rdata_reg <= 8'h00;
    end else if (ce) begin
      rdata_reg <= rdata_next;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign reg_rdata = rdata_reg;
  assign contact_detect_active = active_reg;
  assign inphase_channel_enable = chan_reg[blc_pkg::BIT_INPHASE_EN];
  assign quadrature_channel_enable = chan_reg[blc_pkg::BIT_QUAD_EN];
  // 1 moves the quadrature clock onto the in-phase timing
  assign quad_channel_phase_select = phase_reg[blc_pkg::BIT_QUAD_PHASE];
  // 1 moves the in-phase clock onto quadrature timing
  assign inphase_channel_phase_select = phase_reg[blc_pkg::BIT_INPHASE_PHASE];
  assign voltage_drive_magnitude = stim_reg[blc_pkg::BIT_VMAG_LO +: 2];
  assign current_drive_range = stim_reg[blc_pkg::BIT_IRANGE_LO +: 2];
  assign stimulus_minimum = stim_min_reg;
  // shorts the load while set, released as soon as software clears it
  assign drive_short_enable = drv_reg[blc_pkg::BIT_DRIVE_SHORT];
  assign cal_port_switch_enable = cmux_reg[blc_pkg::BIT_PORT_SWITCH];
  assign cal_enable = cmux_reg[blc_pkg::BIT_CAL_EN];
  assign ref_resistor_connect = ref_conn_reg;

endmodule
`default_nettype wire

// File: test/blc_lead_cal_ctrl_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module blc_lead_cal_ctrl_assertions #(
  parameter int unsigned QUAL_CYCLES = blc_pkg::QUAL_CYCLES
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic contact_below_thresh,
  input wire logic irq,
  input wire logic contact_detect_active,
  input wire logic inphase_channel_enable,
  input wire logic quadrature_channel_enable,
  input wire logic inphase_channel_phase_select,
  input wire logic quad_channel_phase_select,
  input wire logic [1:0] voltage_drive_magnitude,
  input wire logic [1:0] current_drive_range,
  input wire logic stimulus_minimum,
  input wire logic drive_short_enable,
  input wire logic cal_port_switch_enable,
  input wire logic cal_enable,
  input wire logic ref_resistor_connect
);
  // ***************************************************************
  // comparator run length
  // ***************************************************************
  int unsigned below_run_reg;
  int unsigned below_run_next;

  // counts unbroken low samples; a counter, since the interval is too long to unroll
  always_comb begin
    below_run_next = below_run_reg;
    if (ce) begin
      below_run_next = (contact_below_thresh && contact_detect_active) ? below_run_reg + 1 : 0;
    end
  end

  always_ff @(posedge clk_sys) begin
    below_run_reg <= nrst ? below_run_next : 0;
  end

  // ***************************************************************
  // properties
  // ***************************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  qual_min_a: assert property (
    $rose(irq) && !$past(reg_wr, 2) |-> below_run_reg >= QUAL_CYCLES) else $error("flag too early");
  status_read_a: assert property (
    $past(reg_rd && ce && reg_addr == 8'h01 && irq) |-> reg_rdata[7]) else $error("flag lost");
  rdata_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data not idle");
  ref_conn_a: assert property (
    ref_resistor_connect == (cal_port_switch_enable && cal_enable)) else $error("ref switch");
  drive_short_a: assert property (
    $past(nrst && ce && reg_wr && reg_addr == 8'h25) |-> drive_short_enable == $past(reg_wdata[5]))
    else $error("drive short");
  phase_sel_a: assert property (
    $past(nrst && ce && reg_wr && reg_addr == 8'h28) |->
    {quad_channel_phase_select, inphase_channel_phase_select} == $past(reg_wdata[3:2]))
    else $error("phase select");
  stim_min_a: assert property (
    stimulus_minimum == (voltage_drive_magnitude == 2'h0 && current_drive_range == 2'h0))
    else $error("minimum stimulus");
  detect_off_a: assert property (
    contact_detect_active |-> !inphase_channel_enable && !quadrature_channel_enable)
    else $error("detect with channels on");
endmodule

bind blc_lead_cal_ctrl blc_lead_cal_ctrl_assertions #(.QUAL_CYCLES(QUAL_CYCLES)) chk_u (
  .clk_sys, .nrst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .contact_below_thresh, .irq, .contact_detect_active, .inphase_channel_enable,
  .quadrature_channel_enable, .inphase_channel_phase_select, .quad_channel_phase_select,
  .voltage_drive_magnitude, .current_drive_range, .stimulus_minimum, .drive_short_enable,
  .cal_port_switch_enable, .cal_enable, .ref_resistor_connect);
`default_nettype wire

// File: test/blc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module blc_host_model (
  input wire logic clk_sys,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  // ***************************************************************
  // bus cycles
  // ***************************************************************
  // idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // a spare edge after the strobe, so back-to-back calls never assign it twice at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask

  // data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk_sys);
  endtask

  // ***************************************************************
  // firmware steps
  // ***************************************************************
  // channels off before detection is armed
  task automatic arm_detect();
    wr(8'h20, 8'h00);
    wr(8'h83, 8'h01);
  endtask

  // second read tells whether contact persists
  task automatic status_twice(output logic [7:0] first, output logic [7:0] second);
    rd(8'h01, first);
    rd(8'h01, second);
  endtask
endmodule
`default_nettype wire

// File: test/blc_lead_cal_ctrl_bench.sv
`timescale 1ns/10ps
`default_nettype none
module blc_lead_cal_ctrl_bench;
  localparam int unsigned N = 8;
  logic clk_sys, nrst, ce, contact_below_thresh, reg_wr, reg_rd, irq, contact_detect_active;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic inphase_channel_enable, quadrature_channel_enable, inphase_channel_phase_select;
  logic quad_channel_phase_select, stimulus_minimum, drive_short_enable;
  logic cal_port_switch_enable, cal_enable, ref_resistor_connect;
  logic [1:0] voltage_drive_magnitude, current_drive_range;
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;

  blc_lead_cal_ctrl #(.QUAL_CYCLES(N)) dut_u (
    .clk_sys, .nrst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .contact_below_thresh, .irq, .contact_detect_active, .inphase_channel_enable,
    .quadrature_channel_enable, .inphase_channel_phase_select, .quad_channel_phase_select,
    .voltage_drive_magnitude, .current_drive_range, .stimulus_minimum, .drive_short_enable,
    .cal_port_switch_enable, .cal_enable, .ref_resistor_connect);

  blc_host_model host_u (.clk_sys, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);

  // ***************************************************************
  // clock, timeout, report
  // ***************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // whole run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ***************************************************************
  // scenarios
  // ***************************************************************
  // every control register in turn: reset value, all ones, then zero again; event status checked at reset only
  task automatic t_regs();
    logic [7:0] offs [7] = '{8'h20, 8'h22, 8'h25, 8'h28, 8'h41, 8'h81, 8'h83};
    logic [7:0] msks [7] = '{8'h03, 8'h3c, 8'h20, 8'h0c, 8'h03, 8'h80, 8'h01};
    logic [7:0] d;
    host_u.rd(8'h01, d);
    chk("status reset", 8'h00, d);
    chk("min stimulus reset", 8'h01, {7'h0, stimulus_minimum});
    foreach (offs[i]) begin
      host_u.rd(offs[i], d);
      chk("reg reset", 8'h00, d);
      host_u.wr(offs[i], 8'hff);
      host_u.rd(offs[i], d);
      chk("reg ones", msks[i], d);
    end
    foreach (offs[i]) begin
      host_u.wr(offs[i], 8'h00);
    end
    host_u.wr(8'h30, 8'hff);
    host_u.rd(8'h30, d);
    chk("unmapped", 8'h00, d);
    // a frozen clock enable must swallow the write
    ce <= 1'b0;
    host_u.wr(8'h25, 8'h20);
    ce <= 1'b1;
    host_u.rd(8'h25, d);
    chk("write while frozen", 8'h00, d);
  endtask

  // calibration steps in firmware order, outputs judged at each step
  task automatic t_cal();
    host_u.wr(8'h22, 8'h00);
    chk("min stimulus", 8'h01, {7'h0, stimulus_minimum});
    host_u.wr(8'h25, 8'h20);
    chk("short on", 8'h01, {7'h0, drive_short_enable});
    host_u.wr(8'h20, 8'h03);
    chk("channels", 8'h03, {6'h0, quadrature_channel_enable, inphase_channel_enable});
    host_u.wr(8'h22, 8'h14);
    chk("not min", 8'h00, {7'h0, stimulus_minimum});
    chk("drive fields", 8'h05, {4'h0, voltage_drive_magnitude, current_drive_range});
    host_u.wr(8'h25, 8'h00);
    chk("short off", 8'h00, {7'h0, drive_short_enable});
    host_u.wr(8'h28, 8'h08);
    chk("quad to inphase", 8'h02, {6'h0, quad_channel_phase_select,
      inphase_channel_phase_select});
    host_u.wr(8'h28, 8'h04);
    chk("inphase to quad", 8'h01, {6'h0, quad_channel_phase_select,
      inphase_channel_phase_select});
    for (int i = 0; i < 4; i++) begin
      host_u.wr(8'h41, 8'(i));
      chk("ref connect", {7'h0, i == 3}, {7'h0, ref_resistor_connect});
      chk("cal bits", 8'(i), {6'h0, cal_port_switch_enable, cal_enable});
    end
    host_u.wr(8'h41, 8'h00);
    host_u.wr(8'h28, 8'h00);
  endtask

  // qualification with a break, interrupt, clear on read, mask and gating
  task automatic t_contact();
    logic [7:0] a;
    logic [7:0] b;
    host_u.arm_detect();
    host_u.wr(8'h81, 8'h80);
    chk("detect active", 8'h01, {7'h0, contact_detect_active});
    host_u.rd(8'h83, a);
    chk("detect reg", 8'h03, a);
    contact_below_thresh <= 1'b1;
    repeat (N - 1) @(posedge clk_sys);
    contact_below_thresh <= 1'b0;
    @(posedge clk_sys);
    contact_below_thresh <= 1'b1;
    repeat (N) @(posedge clk_sys);
    #1 chk("irq early", 8'h00, {7'h0, irq});
    repeat (2) @(posedge clk_sys);
    #1 chk("irq raised", 8'h01, {7'h0, irq});
    @(posedge clk_sys);
    host_u.status_twice(a, b);
    chk("status first", 8'h80, a);
    chk("status persists", 8'h80, b);
    contact_below_thresh <= 1'b0;
    // the timer sees the drop one edge later, so let it leave the held state first
    @(posedge clk_sys);
    host_u.status_twice(a, b);
    chk("status sticky", 8'h80, a);
    chk("status cleared", 8'h00, b);
    chk("irq cleared", 8'h00, {7'h0, irq});
    host_u.wr(8'h81, 8'h00);
    contact_below_thresh <= 1'b1;
    repeat (N + 3) @(posedge clk_sys);
    #1 chk("irq masked", 8'h00, {7'h0, irq});
    @(posedge clk_sys);
    host_u.rd(8'h01, a);
    chk("masked flag", 8'h80, a);
    contact_below_thresh <= 1'b0;
    host_u.wr(8'h20, 8'h01);
    chk("gated off", 8'h00, {7'h0, contact_detect_active});
    // flag left set once the input dropped; a written one clears it
    host_u.wr(8'h01, 8'h80);
    host_u.rd(8'h01, a);
    chk("flag w1c", 8'h00, a);
    contact_below_thresh <= 1'b1;
    host_u.rd(8'h83, a);
    chk("detect bits", 8'h05, a);
  endtask

  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    contact_below_thresh = 1'b0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    t_regs();
    t_cal();
    t_contact();
    wrap_up();
  end
endmodule
`default_nettype wire
